// *** hw/csel_pkg.sv ***
// Constants and types shared by the chip-select block.
// Assumes a 20-bit processor address and a 32-bit APB register bus.
`default_nettype none

package csel_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_UPPER = 8'h00;
    localparam logic [7:0] OFS_LOWER = 8'h04;
    localparam logic [7:0] OFS_MID = 8'h08;
    localparam logic [7:0] OFS_PERI = 8'h0c;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int F_LOW = 0;
    localparam int F_EN = 7;
    localparam int F_MID_SIZE = 8;
    localparam int F_PERI_MEM = 16;
    localparam int F_P5_SEL = 17;
    localparam int F_P6_SEL = 18;
    localparam int F_ENH = 0;

    // ------------------------------------------------------------
    // Limits and fixed values
    // ------------------------------------------------------------
    localparam logic [3:0] UPPER_SIZE_MAX = 4'h8; // 1K shifted by 8 is 256K.
    localparam logic [2:0] MID_SIZE_MAX = 3'h6; // 8K shifted by 6 is 512K.
    localparam logic [15:0] COPROC_PORT = 16'h00f8; // Eight I/O bytes.
    localparam logic [1:0] STRAP_WAIT = 2'h2; // Synchroniser depth.

    // Programmed decode settings.
    typedef struct packed {
        logic up_en;
        logic [3:0] up_size;
        logic lo_en;
        logic [3:0] lo_size;
        logic mid_en;
        logic [6:0] mid_base;
        logic [2:0] mid_size;
        logic peri_en;
        logic [9:0] peri_base;
        logic peri_mem;
        logic p5_sel;
        logic p6_sel;
        logic enh;
    } csel_cfg_s;

    // The top 1K boot block is selected out of reset; all else is off.
    localparam csel_cfg_s CFG_RST = '{up_en: 1'b1, default: '0};

endpackage

`default_nettype wire

// *** hw/csel_dec_if.sv ***
// Interface between the chip-select top and its address decoder.
// Assumes both ends run on the same clock; the decode is combinational.
`default_nettype none

interface csel_dec_if;
    import csel_pkg::*;

    logic [19:0] addr;
    logic is_io;
    csel_cfg_s cfg;
    logic upper_hit;
    logic lower_hit;
    logic coproc_hit;
    logic [3:0] mid_hit;
    logic [6:0] peri_hit;

    modport req (output addr, is_io, cfg,
                 input upper_hit, lower_hit, coproc_hit, mid_hit, peri_hit);
    modport dec (input addr, is_io, cfg,
                 output upper_hit, lower_hit, coproc_hit, mid_hit, peri_hit);
endinterface

`default_nettype wire

// *** hw/csel_sync.sv ***
// Two-stage synchroniser for pin inputs.
// Assumes inputs idle high, as the pins are pulled up.
`default_nettype none

module csel_sync #(
    parameter int W = 4
) (
    input wire logic clk, // Sampling clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [W-1:0] d, // Asynchronous inputs.
    output logic [W-1:0] q // Synchronised inputs.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } csel_sync_s;

    csel_sync_s st_r;
    csel_sync_s st_nxt;

    // The first stage feeds only the second.
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // Both stages reset to the idle high level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

    if (W < 1) begin : g_chk
        $error("csel_sync needs a positive width.");
    end
endmodule // csel_sync

`default_nettype wire

// *** hw/csel_decode.sv ***
// Address decoder for upper, lower, mid-range and peripheral selects.
// Assumes the programmed settings are held stable by the top.
`default_nettype none

module csel_decode
    import csel_pkg::*;
(
    csel_dec_if.dec dif // Address in, hits out.
);
    // Mask of the low kilobyte bits covered by a block of 2^k units.
    function automatic logic [9:0] low_mask(input logic [3:0] k);
        low_mask = (10'h001 << k) - 10'h001;
    endfunction

    logic [9:0] kb;
    logic [9:0] mid_mask;
    logic [6:0] mm;
    logic [1:0] midx;
    logic mem;

    assign kb = dif.addr[19:10];
    assign mem = !dif.is_io;

    // Upper, lower and peripheral regions compare the kilobyte number, the mid range the 8K number, against its block.
    always_comb begin
        mid_mask = low_mask({1'b0, dif.cfg.mid_size});
        mm = mid_mask[6:0];
        midx = 2'(dif.addr >> (5'd11 + {2'b00, dif.cfg.mid_size}));
        dif.upper_hit = mem && dif.cfg.up_en
            && ((kb | low_mask(dif.cfg.up_size)) == 10'h3ff);
        dif.lower_hit = mem && dif.cfg.lo_en
            && ((kb & ~low_mask(dif.cfg.lo_size)) == 10'h000);
        dif.mid_hit = 4'h0;
        if (mem && dif.cfg.mid_en
            && ((dif.addr[19:13] & ~mm) == (dif.cfg.mid_base & ~mm))) begin
            dif.mid_hit = 4'h1 << midx;
        end
        dif.peri_hit = 7'h00;
        if (dif.cfg.peri_en && (kb == dif.cfg.peri_base)
            && (dif.cfg.peri_mem ? mem : dif.is_io)) begin
            dif.peri_hit = 7'h01 << dif.addr[9:7];
        end
        dif.coproc_hit = dif.is_io && (dif.addr[19:16] == 4'h0)
            && (dif.addr[15:3] == COPROC_PORT[15:3]);
    end
endmodule // csel_decode

`default_nettype wire

// *** hw/csel_chip_select.sv ***
// Memory and peripheral chip-select unit with APB configuration.
// Assumes bus_* inputs come from processor logic on pclk; pins are async.
//
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none

module csel_chip_select
    import csel_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic pclk, // APB and bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [AW-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic bus_ref, // A bus reference is valid.
    input wire logic [19:0] bus_addr, // Reference address.
    input wire logic bus_is_io, // Reference is to I/O space.
    input wire logic bus_hold, // Another master holds the bus.
    output logic upper_mem_select_n_o, // Upper select level.
    output logic upper_mem_select_n_oe, // Upper select drive.
    input wire logic upper_mem_select_n_i, // Upper select pin level.
    output logic lower_mem_select_n_o, // Lower select level.
    output logic lower_mem_select_n_oe, // Lower select drive.
    input wire logic lower_mem_select_n_i, // Lower select pin level.
    output logic mid_select0_or_coproc_request_o, // Mid 0 level.
    output logic mid_select0_or_coproc_request_oe, // Mid 0 drive.
    input wire logic mid_select0_or_coproc_request_i, // Mid 0 pin level.
    output logic mid_select1_or_coproc_fault_o, // Mid 1 level.
    output logic mid_select1_or_coproc_fault_oe, // Mid 1 drive.
    input wire logic mid_select1_or_coproc_fault_i, // Mid 1 pin level.
    output logic mid_select2_n_o, // Mid 2 level.
    output logic mid_select2_n_oe, // Mid 2 drive.
    output logic mid_select3_or_coproc_select_o, // Mid 3 level.
    output logic mid_select3_or_coproc_select_oe, // Mid 3 drive.
    output logic [4:0] periph_select_n_o, // Peripheral 0 to 4 levels.
    output logic periph_select_n_oe, // Peripheral 0 to 4 drive.
    output logic periph_select5_or_addr1_o, // Pin five level.
    output logic periph_select5_or_addr1_oe, // Pin five drive.
    output logic periph_select6_or_addr2_o, // Pin six level.
    output logic periph_select6_or_addr2_oe, // Pin six drive.
    output logic select_pullup_en, // Weak strap pull-ups on.
    output logic float_test_mode, // High-impedance test mode.
    output logic coproc_xfer_request, // Coprocessor asks a transfer.
    output logic coproc_fault // Coprocessor reports an error.
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        csel_cfg_s cfg;
        logic strap_done;
        logic [1:0] strap_cnt;
        logic float_mode;
        logic a1;
        logic a2;
        logic upper_mem_select_n;
        logic lower_mem_select_n;
        logic [3:0] mcs;
        logic [6:0] pcs;
        logic [31:0] prdata;
        logic pslverr;
    } csel_state_s;

    localparam csel_state_s ST_RST = '{cfg: CFG_RST, upper_mem_select_n: 1'b1, lower_mem_select_n: 1'b1,
        mcs: 4'hf, pcs: 7'h7f, default: '0};

    csel_state_s st_r;
    csel_state_s st_nxt;
    logic [3:0] pin_s;
    logic live;
    logic drive;
    logic enh;

    // Size codes beyond the largest block are held at the largest.
    function automatic logic [3:0] clamp_size(input logic [3:0] k);
        clamp_size = (k > UPPER_SIZE_MAX) ? UPPER_SIZE_MAX : k;
    endfunction

    if (AW < 8) begin : g_chk
        $error("csel_chip_select needs at least eight address bits.");
    end

    // ------------------------------------------------------------
    // Pin synchronisers and decoder
    // ------------------------------------------------------------
    csel_sync #(.W(4)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({mid_select1_or_coproc_fault_i, mid_select0_or_coproc_request_i,
            lower_mem_select_n_i, upper_mem_select_n_i}),
        .q(pin_s)
    );

    csel_dec_if u_dif ();

    assign u_dif.addr = bus_addr;
    assign u_dif.is_io = bus_is_io;
    assign u_dif.cfg = st_r.cfg;

    csel_decode u_dec (
        .dif(u_dif.dec)
    );

    assign live = bus_ref && !bus_hold;
    assign enh = st_r.cfg.enh;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!st_r.strap_done) begin
            if (st_r.strap_cnt == STRAP_WAIT) begin
                st_nxt.strap_done = 1'b1;
                st_nxt.float_mode = !pin_s[0] && !pin_s[1];
            end else begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            end
        end
        if (live) begin
            st_nxt.a1 = bus_addr[1];
            st_nxt.a2 = bus_addr[2];
        end
        st_nxt.upper_mem_select_n = !(live && u_dif.upper_hit);
        st_nxt.lower_mem_select_n = !(live && u_dif.lower_hit);
        st_nxt.mcs = ~({4{live}} & u_dif.mid_hit);
        st_nxt.pcs = ~({7{live}} & u_dif.peri_hit);
        if (enh) begin
            st_nxt.mcs = {!(live && u_dif.coproc_hit), u_dif.mid_hit[2] ? !live : 1'b1,
                2'b11};
        end
        // Register reads are prepared in the setup phase.
        if (psel && !penable) begin
            st_nxt.prdata = 32'h0;
            st_nxt.pslverr = 1'b0;
            case (paddr[7:0])
                OFS_UPPER: begin
                    st_nxt.prdata[F_EN] = st_r.cfg.up_en;
                    st_nxt.prdata[F_LOW +: 4] = st_r.cfg.up_size;
                end
                OFS_LOWER: begin
                    st_nxt.prdata[F_EN] = st_r.cfg.lo_en;
                    st_nxt.prdata[F_LOW +: 4] = st_r.cfg.lo_size;
                end
                OFS_MID: begin
                    st_nxt.prdata[F_EN] = st_r.cfg.mid_en;
                    st_nxt.prdata[F_LOW +: 7] = st_r.cfg.mid_base;
                    st_nxt.prdata[F_MID_SIZE +: 3] = st_r.cfg.mid_size;
                end
                OFS_PERI: begin
                    st_nxt.prdata[F_LOW +: 10] = st_r.cfg.peri_base;
                    st_nxt.prdata[F_EN + 8] = st_r.cfg.peri_en;
                    st_nxt.prdata[F_PERI_MEM] = st_r.cfg.peri_mem;
                    st_nxt.prdata[F_P5_SEL] = st_r.cfg.p5_sel;
                    st_nxt.prdata[F_P6_SEL] = st_r.cfg.p6_sel;
                end
                OFS_MODE: begin
                    st_nxt.prdata[F_ENH] = enh;
                end
                OFS_STATUS: begin
                    st_nxt.prdata[5:0] = {bus_hold, st_r.a2, st_r.a1,
                        coproc_fault, coproc_xfer_request, st_r.float_mode};
                    st_nxt.pslverr = pwrite;
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
            if (paddr[AW-1:0] > AW'(OFS_STATUS)) begin
                st_nxt.pslverr = 1'b1;
            end
        end
        // Writes take effect at the access edge.
        if (psel && penable && pwrite && !st_r.pslverr) begin
            case (paddr[7:0])
                OFS_UPPER: begin
                    st_nxt.cfg.up_en = pwdata[F_EN];
                    st_nxt.cfg.up_size = clamp_size(pwdata[F_LOW +: 4]);
                end
                OFS_LOWER: begin
                    st_nxt.cfg.lo_en = pwdata[F_EN];
                    st_nxt.cfg.lo_size = clamp_size(pwdata[F_LOW +: 4]);
                end
                OFS_MID: begin
                    st_nxt.cfg.mid_en = pwdata[F_EN];
                    st_nxt.cfg.mid_base = pwdata[F_LOW +: 7];
                    st_nxt.cfg.mid_size = (pwdata[F_MID_SIZE +: 3] > MID_SIZE_MAX)
                        ? MID_SIZE_MAX : pwdata[F_MID_SIZE +: 3];
                end
                OFS_PERI: begin
                    st_nxt.cfg.peri_base = pwdata[F_LOW +: 10];
                    st_nxt.cfg.peri_en = pwdata[F_EN + 8];
                    st_nxt.cfg.peri_mem = pwdata[F_PERI_MEM];
                    st_nxt.cfg.p5_sel = pwdata[F_P5_SEL];
                    st_nxt.cfg.p6_sel = pwdata[F_P6_SEL];
                end
                OFS_MODE: begin
                    st_nxt.cfg.enh = pwdata[F_ENH];
                end
                default: begin
                end
            endcase
        end
    end

    // All state resets to constants.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // float all pins
    assign drive = st_r.strap_done && !st_r.float_mode;
    assign select_pullup_en = !st_r.strap_done;
    assign float_test_mode = st_r.float_mode;
    assign prdata = st_r.prdata;
    assign pready = 1'b1;
    assign pslverr = st_r.pslverr;

    assign upper_mem_select_n_o = st_r.upper_mem_select_n;
    assign upper_mem_select_n_oe = drive;
    assign lower_mem_select_n_o = st_r.lower_mem_select_n;
    assign lower_mem_select_n_oe = drive;
    assign mid_select0_or_coproc_request_o = st_r.mcs[0];
    assign mid_select0_or_coproc_request_oe = drive && !enh;
    assign mid_select1_or_coproc_fault_o = st_r.mcs[1];
    assign mid_select1_or_coproc_fault_oe = drive && !enh;
    assign coproc_xfer_request = enh && pin_s[2];
    assign coproc_fault = enh && !pin_s[3];
    assign mid_select2_n_o = st_r.mcs[2];
    assign mid_select2_n_oe = drive;
    assign mid_select3_or_coproc_select_o = st_r.mcs[3];
    assign mid_select3_or_coproc_select_oe = drive;
    assign periph_select_n_o = st_r.pcs[4:0];
    assign periph_select_n_oe = drive;
    assign periph_select5_or_addr1_o = st_r.cfg.p5_sel ? st_r.pcs[5] : st_r.a1;
    assign periph_select6_or_addr2_o = st_r.cfg.p6_sel ? st_r.pcs[6] : st_r.a2;
    assign periph_select5_or_addr1_oe = drive;
    assign periph_select6_or_addr2_oe = drive;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_STRAP_SAMPLE: assert property (
        $rose(st_r.strap_done) |-> st_r.float_mode == ($past(pin_s[1:0]) == 2'b00))
        else $error("Strap sample gave the wrong mode.");
    AST_FLOAT_PINS: assert property (
        st_r.float_mode |-> !upper_mem_select_n_oe && !lower_mem_select_n_oe
            && !periph_select5_or_addr1_oe && !mid_select3_or_coproc_select_oe)
        else $error("A pin is driven in float mode.");
    AST_FLOAT_KEEP: assert property (
        st_r.float_mode |=> st_r.float_mode [*4])
        else $error("Float mode was left without reset.");
    AST_PULLUP: assert property (
        select_pullup_en |-> !upper_mem_select_n_oe && !lower_mem_select_n_oe
            ##[0:3] !select_pullup_en)
        else $error("Pull-ups on while driving or too long.");
    AST_UPPER: assert property (
        live && !bus_is_io && st_r.cfg.up_en && (&bus_addr[19:10])
            |=> !upper_mem_select_n_o)
        else $error("Upper select missed a top reference.");
    AST_LOWER: assert property (
        live && !bus_is_io && st_r.cfg.lo_en && bus_addr[19:10] == 10'h000
            |=> !lower_mem_select_n_o)
        else $error("Lower select missed a bottom reference.");
    AST_MID_ONE: assert property (
        $onehot0(~st_r.mcs) && $onehot0(~st_r.pcs))
        else $error("More than one select of a group is active.");
    AST_PERI: assert property (
        !periph_select_n_o[0] |-> $past(live) && $past(st_r.cfg.peri_en)
            && $past(bus_addr[9:7]) == 3'h0)
        else $error("Peripheral select 0 without its reference.");
    AST_IDLE: assert property (
        !bus_ref |=> st_r.upper_mem_select_n && st_r.lower_mem_select_n && (&st_r.mcs) && (&st_r.pcs))
        else $error("A select is active without a reference.");
    AST_COPROC_IN: assert property (
        enh |-> !mid_select0_or_coproc_request_oe && !mid_select1_or_coproc_fault_oe)
        else $error("Coprocessor input pin is driven.");
    AST_NPS: assert property (
        $fell(mid_select3_or_coproc_select_o) && enh
            |-> $past(live) && ($past(bus_is_io) || !$past(enh)))
        else $error("Coprocessor select without I/O reference.");
    AST_A1: assert property (
        live && !st_r.cfg.p5_sel && drive ##1 !st_r.cfg.p5_sel
            |-> periph_select5_or_addr1_o == $past(bus_addr[1]))
        else $error("Pin five does not show latched A1.");
    AST_A2: assert property (
        live && !st_r.cfg.p6_sel && drive ##1 !st_r.cfg.p6_sel
            |-> periph_select6_or_addr2_o == $past(bus_addr[2]))
        else $error("Pin six does not show latched A2.");
    AST_HOLD: assert property (
        bus_hold && drive |-> periph_select5_or_addr1_oe && periph_select6_or_addr2_oe)
        else $error("Pin five or six floats during hold.");
    AST_A_HOLD: assert property (
        bus_hold [*2] |-> $stable(st_r.a1) && $stable(st_r.a2))
        else $error("Latched address changed during hold.");

    COV_FLOAT: cover property ($rose(st_r.float_mode));
    COV_NPS: cover property (enh && !st_r.mcs[3]);
    COV_HOLD_A1: cover property (bus_hold [*3] ##0 !st_r.cfg.p5_sel);
    COV_MID: cover property (!st_r.mcs[2] ##1 !st_r.pcs[6]);
endmodule // csel_chip_select

`default_nettype wire

// *** verif/csel_pin_model.sv ***
// Board and coprocessor model around the strap and mid-range pins.
// Assumes the same clock as the device; bit order upper, lower, mid 0, mid 1.
`default_nettype none

module csel_pin_model (
    input wire logic clk, // Clock.
    input wire logic pu, // Weak strap pull-ups on.
    input wire logic strap, // Strap jumper pulls pins low.
    input wire logic cp_req, // Coprocessor asks a transfer.
    input wire logic cp_err, // Coprocessor has an error.
    input wire logic [3:0] o, // Device pin levels.
    input wire logic [3:0] oe, // Device pin drives.
    output logic [3:0] i // Resolved pin levels.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_r = 1'b0;
    // A released line with no pull-up wanders every cycle.
    always @(posedge clk) tog_r <= ~tog_r;
    // jumper and weak pull-ups, coprocessor drives released pins.
    assign i = {oe[3] ? o[3] : ~cp_err,
                oe[2] ? o[2] : cp_req,
                strap ? 1'b0 : oe[1] ? o[1] : pu ? 1'b1 : tog_r,
                strap ? 1'b0 : oe[0] ? o[0] : pu ? 1'b1 : tog_r};
endmodule // csel_pin_model

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench: APB set-up, bus references, pin checks.
// Assumes csel_chip_select and csel_pin_model are compiled before it.
`default_nettype none

module tb_top
    import csel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, bus_ref = 1'b0, bus_is_io = 1'b0, bus_hold = 1'b0;
    logic [19:0] bus_addr = 20'h0;
    logic strap = 1'b0, cp_req = 1'b0, cp_err = 1'b0;
    wire logic [3:0] pin_o, pin_oe;
    logic [3:0] pin_i;
    logic m2_o, m2_oe, m3_o, m3_oe, p_oe, p5_o, p5_oe, p6_o, p6_oe, pu, ftm, creq, cflt;
    logic [4:0] p_o;
    int n_mismatch = 0, compares = 0, cyc = 0;

    csel_chip_select #(.AW(8)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .bus_ref, .bus_addr, .bus_is_io, .bus_hold,
        .upper_mem_select_n_o(pin_o[0]), .upper_mem_select_n_oe(pin_oe[0]),
        .upper_mem_select_n_i(pin_i[0]), .lower_mem_select_n_o(pin_o[1]),
        .lower_mem_select_n_oe(pin_oe[1]), .lower_mem_select_n_i(pin_i[1]),
        .mid_select0_or_coproc_request_o(pin_o[2]),
        .mid_select0_or_coproc_request_oe(pin_oe[2]),
        .mid_select0_or_coproc_request_i(pin_i[2]),
        .mid_select1_or_coproc_fault_o(pin_o[3]), .mid_select1_or_coproc_fault_oe(pin_oe[3]),
        .mid_select1_or_coproc_fault_i(pin_i[3]), .mid_select2_n_o(m2_o), .mid_select2_n_oe(m2_oe),
        .mid_select3_or_coproc_select_o(m3_o), .mid_select3_or_coproc_select_oe(m3_oe),
        .periph_select_n_o(p_o), .periph_select_n_oe(p_oe),
        .periph_select5_or_addr1_o(p5_o), .periph_select5_or_addr1_oe(p5_oe),
        .periph_select6_or_addr2_o(p6_o), .periph_select6_or_addr2_oe(p6_oe),
        .select_pullup_en(pu), .float_test_mode(ftm), .coproc_xfer_request(creq),
        .coproc_fault(cflt)
    );
    csel_pin_model i_pins (.clk(pclk), .pu, .strap, .cp_req, .cp_err, .o(pin_o), .oe(pin_oe),
        .i(pin_i));

    // Clock of 4 ns period.
    initial begin
        forever #2 pclk = ~pclk;
    end
    // Cycle ceiling against a hang.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end

    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        if (!w) chk(prdata, e);
        chk(pslverr, er);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One-cycle bus reference; selects are looked at the cycle after.
    task automatic bref(input logic [19:0] a, input logic io, input logic h);
        @(posedge pclk);
        bus_ref <= 1'b1;
        bus_addr <= a;
        bus_is_io <= io;
        bus_hold <= h;
        @(posedge pclk);
        bus_ref <= 1'b0;
        #1;
    endtask
    // Reset with the strap jumper set or not, held past strap sampling.
    task automatic rst(input logic s);
        presetn <= 1'b0;
        strap <= s;
        repeat (3) @(posedge pclk);
        chk({pu, pin_oe, p_oe}, 6'h20);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        strap <= 1'b0;
        #1;
        chk({pu, ftm}, {1'b0, s});
    endtask

    // -------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------
    initial begin
        rst(1'b0);
        apb(1'b0, OFS_UPPER, 32'h0, 32'h80, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        bref(20'hffff0, 1'b0, 1'b0);
        chk(pin_o[1:0], 2'h2);
        apb(1'b1, OFS_LOWER, 32'h80, 32'h0, 1'b0);
        bref(20'h003fe, 1'b0, 1'b0);
        chk(pin_o[1:0], 2'h1);
        bref(20'h00400, 1'b0, 1'b0);
        chk(pin_o[1:0], 2'h3);
        apb(1'b1, OFS_MID, 32'h88, 32'h0, 1'b0);
        bref(20'h10000, 1'b0, 1'b0);
        chk({m3_o, m2_o, pin_o[3:2]}, 4'he);
        bref(20'h11000, 1'b0, 1'b0);
        chk({m3_o, m2_o, pin_o[3:2]}, 4'hb);
        apb(1'b1, OFS_PERI, 32'h8010, 32'h0, 1'b0);
        bref(20'h04004, 1'b1, 1'b0);
        chk({p_o, p6_o}, 6'h3d);
        bref(20'h04082, 1'b1, 1'b0);
        chk({p_o, p5_o}, 6'h3b);
        bref(20'h04000, 1'b1, 1'b1);
        chk({p_o, p5_o, p5_oe, p6_oe}, 8'hff);
        apb(1'b1, OFS_PERI, 32'h68010, 32'h0, 1'b0);
        bref(20'h04280, 1'b1, 1'b0);
        chk({p6_o, p5_o}, 2'h2);
        bref(20'h04300, 1'b1, 1'b0);
        chk({p6_o, p5_o}, 2'h1);
        apb(1'b1, OFS_MODE, 32'h1, 32'h0, 1'b0);
        cp_req <= 1'b1;
        cp_err <= 1'b1;
        bref(20'h000f8, 1'b1, 1'b0);
        chk({m3_o, pin_oe[3:2]}, 3'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk({creq, cflt}, 2'h3);
        bref(20'h10000, 1'b0, 1'b0);
        chk(m3_o, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0, 32'h6, 1'b0);
        rst(1'b1);
        bref(20'hffff0, 1'b0, 1'b0);
        chk({pin_oe, m2_oe, m3_oe, p_oe, p5_oe, p6_oe, ftm}, 10'h1);
        finish_test();
    end
endmodule // tb_top

`default_nettype wire
